// [tcr_consts.svh]
/*
  Constants of the tilt control register bank: byte addresses, command codes,
  status bit positions and the angle wrap value.
  Assumes inclusion by bare name from the package, through which the design modules get its macros.
*/
`ifndef TCR_CONSTS_SVH
`define TCR_CONSTS_SVH

// ==========================================================
// register byte addresses (lower byte; upper byte is +1)
`define TCR_OFS_INCLINE_OFFSET_NULL 6'h18
`define TCR_OFS_ALARM1_THRESHOLD 6'h20
`define TCR_OFS_ALARM2_THRESHOLD 6'h22
`define TCR_OFS_ALARM1_SAMPLE_PERIOD 6'h24
`define TCR_OFS_ALARM2_SAMPLE_PERIOD 6'h26
`define TCR_OFS_ALARM_SOURCE_CONTROL 6'h28
`define TCR_OFS_AUX_CONVERTER_LEVEL 6'h30
`define TCR_OFS_AUX_IO_CONTROL 6'h32
`define TCR_OFS_MISC_CONTROL 6'h34
`define TCR_OFS_ADC_SAMPLE_PERIOD 6'h36
`define TCR_OFS_MOVING_AVERAGE_LENGTH 6'h38
`define TCR_OFS_SLEEP_DURATION_COUNT 6'h3A
`define TCR_OFS_SYSTEM_STATUS 6'h3C
`define TCR_OFS_SYSTEM_COMMAND 6'h3E
`define TCR_OFS_TILT_360_OUTPUT 6'h0C
`define TCR_OFS_TILT_SIGNED_OUTPUT 6'h0E

// ==========================================================
// number of read/write control registers and which are nonvolatile
`define TCR_NUM_RW 12
`define TCR_NV_MASK 12'h73F
`define TCR_RW_RESET 16'h0000

// ==========================================================
// frame fields
`define TCR_FRM_WRITE 2'h2
`define TCR_FRM_READ 2'h0

// ==========================================================
// command codes
`define TCR_CMD_AUTONULL 8'h01
`define TCR_CMD_FACTORY 8'h02
`define TCR_CMD_FLASH_UPDATE 8'h08

// ==========================================================
// status bit positions
`define TCR_ST_FRAME_ERR 0
`define TCR_ST_NULL_RANGE_ERR 1
`define TCR_ST_NV_VALID 2

// ==========================================================
// angle arithmetic, 0.025 degree per code
`define TCR_TILT_WRAP 15'h3840
`define TCR_TILT_HALF 14'h1C20
`define TCR_FLASH_SIG 16'hA5C3

`endif

// [tcr_pkg.sv]
/*
  Types shared by the tilt control register bank modules.
  Assumes tcr_consts.svh is on the include path.
*/
package tcr_pkg;
  `include "tcr_consts.svh"

  typedef logic [15:0] tcr_word_t;
  typedef logic [`TCR_NUM_RW-1:0][15:0] tcr_ctrl_t;
  typedef enum logic [0:0] {TCR_ST_LOAD, TCR_ST_RUN} tcr_state_t;
endpackage

// [tcr_frame_if.sv]
/*
  Carrier between the serial link (serial clock domain) and the register core
  (system clock domain). rx_word is stable between frames; rx_tgl flips once per
  completed frame; tx_word is loaded by the core after each read frame and held through the next frame.
*/
`timescale 1ns/1ps
interface tcr_frame_if;
  logic [15:0] rx_word;
  logic rx_tgl;
  logic [15:0] tx_word;

  modport link (
    output rx_word,
    output rx_tgl,
    input tx_word
  );
  modport core (
    input rx_word,
    input rx_tgl,
    output tx_word
  );
endinterface

// [tcr_byte_reg.sv]
/*
  One 16-bit control register with separately writable bytes, a reload
  port for the power-up restore and a whole-word load for internal commands.
  Assumes all controls are on clk and mutually resolved by priority here.
*/
`timescale 1ns/1ps
module tcr_byte_reg
  import tcr_pkg::*;
#(
  parameter logic [15:0] RESET_VAL = 16'h0000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // restore from nonvolatile image
  input wire logic init,
  input wire logic [15:0] init_val,
  // host byte writes
  input wire logic wr_lo,
  input wire logic wr_hi,
  input wire logic [7:0] wr_data,
  // internal whole-word load
  input wire logic ld,
  input wire logic [15:0] ld_val,
  // contents
  output logic [15:0] q
);
  logic [15:0] q_ff;
  logic [15:0] nxt_q;

  // ==========================================================
  // next value: restore, then command load, then host bytes
  assign nxt_q = init ? init_val :
                 ld ? ld_val :
                 {wr_hi ? wr_data : q_ff[15:8], wr_lo ? wr_data : q_ff[7:0]};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q_ff <= RESET_VAL;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule

// [tcr_spi_link.sv]
/*
  Serial slave front end: shifts 16-bit frames in on rising serial clock,
  drives read data out on falling serial clock, msb first.
  Assumes serial clock idles high and stands still while chip select is high;
  the core holds tx_word stable for the whole frame.
*/
`timescale 1ns/1ps
module tcr_spi_link
  import tcr_pkg::*;
(
  // system reset, only to clear the received word and the frame toggle
  input wire logic rst_b,
  // serial pins
  input wire logic sclk,
  input wire logic cs_b,
  input wire logic din,
  output logic dout,
  output logic dout_oe,
  // toward the core
  tcr_frame_if.link fr
);
  logic [3:0] rx_cnt_ff;
  logic [14:0] rx_sh_ff;
  logic [4:0] tx_cnt_ff;
  logic [3:0] tx_sel;

  // ==========================================================
  // receive; chip select high holds the counter cleared, ignoring sclk and din
  always_ff @(posedge sclk or posedge cs_b) begin
    if (cs_b) begin
      rx_cnt_ff <= 4'h0;
      rx_sh_ff <= 15'h0000;
    end else begin
      rx_cnt_ff <= rx_cnt_ff + 4'h1;
      rx_sh_ff <= {rx_sh_ff[13:0], din};
    end
  end

  // the 16th bit completes a frame; word is held until the next frame ends
  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      fr.rx_word <= 16'h0000;
      fr.rx_tgl <= 1'b0;
    end else if (!cs_b && rx_cnt_ff == 4'hF) begin
      fr.rx_word <= {rx_sh_ff, din};
      fr.rx_tgl <= ~fr.rx_tgl;
    end
  end

  // ==========================================================
  // transmit: bit 15 stands from chip select low until the second falling edge
  always_ff @(negedge sclk or posedge cs_b) begin
    if (cs_b) begin
      tx_cnt_ff <= 5'h00;
    end else if (tx_cnt_ff != 5'h10) begin
      tx_cnt_ff <= tx_cnt_ff + 5'h01;
    end
  end

  assign tx_sel = (tx_cnt_ff == 5'h00) ? 4'h0 : 4'(tx_cnt_ff - 5'h01);
  assign dout = fr.tx_word[4'hF - tx_sel];
  assign dout_oe = ~cs_b;
endmodule

// [tcr_bank.sv]
/*
  Tilt control register bank: decodes serial frames into byte writes and word
  reads, holds the control registers, keeps a nonvolatile image that is
  refreshed only on a flash update, and applies the offset null to the tilt
  outputs with autonull and factory restore commands.
  Assumes tilt_raw is synchronous to clk, below 14400, and that the host
  leaves at least 200 ns of chip select high between frames.
*/
`timescale 1ns/1ps
module tcr_bank
  import tcr_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst_b,
  // serial port pins
  input wire logic spi_sclk,
  input wire logic spi_cs_b,
  input wire logic spi_din,
  output logic spi_dout,
  output logic spi_dout_oe,
  // sensor angle, 0.025 degree per code
  input wire logic [13:0] tilt_raw,
  // corrected angles
  output logic [13:0] tilt_360_output,
  output logic [13:0] tilt_signed_output,
  // control register contents for the rest of the device
  output tcr_ctrl_t ctrl_words
);
  localparam logic [5:0] RW_OFS [`TCR_NUM_RW] = '{
    `TCR_OFS_INCLINE_OFFSET_NULL, `TCR_OFS_ALARM1_THRESHOLD, `TCR_OFS_ALARM2_THRESHOLD,
    `TCR_OFS_ALARM1_SAMPLE_PERIOD, `TCR_OFS_ALARM2_SAMPLE_PERIOD, `TCR_OFS_ALARM_SOURCE_CONTROL,
    `TCR_OFS_AUX_CONVERTER_LEVEL, `TCR_OFS_AUX_IO_CONTROL, `TCR_OFS_MISC_CONTROL,
    `TCR_OFS_ADC_SAMPLE_PERIOD, `TCR_OFS_MOVING_AVERAGE_LENGTH, `TCR_OFS_SLEEP_DURATION_COUNT
  };
  localparam logic [`TCR_NUM_RW-1:0] NV_MASK = `TCR_NV_MASK;

  tcr_frame_if fr ();

  // ==========================================================
  // serial link
  tcr_spi_link u_link (
    .rst_b(rst_b),
    .sclk(spi_sclk),
    .cs_b(spi_cs_b),
    .din(spi_din),
    .dout(spi_dout),
    .dout_oe(spi_dout_oe),
    .fr(fr)
  );

  // ==========================================================
  // frame event crossing: toggle through two flops, edge taken after them
  logic tgl_s1_ff;
  logic tgl_s2_ff;
  logic tgl_s3_ff;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
    end else begin
      tgl_s1_ff <= fr.rx_tgl;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
    end
  end

  // ==========================================================
  // frame decode; rx_word is settled long before the synchronised edge
  wire frame_stb = tgl_s2_ff ^ tgl_s3_ff;
  wire [1:0] frame_kind = fr.rx_word[15:14];
  wire [5:0] frame_addr = fr.rx_word[13:8];
  wire [7:0] frame_data = fr.rx_word[7:0];
  wire [4:0] frame_word = frame_addr[5:1];
  wire frame_hi = frame_addr[0];
  wire wr_frame = frame_stb && frame_kind == `TCR_FRM_WRITE;
  wire rd_frame = frame_stb && frame_kind == `TCR_FRM_READ;
  wire bad_frame = frame_stb && !wr_frame && !rd_frame;

  // command is a lower-byte write only; its upper byte is ignored
  wire cmd_wr = wr_frame && frame_addr == `TCR_OFS_SYSTEM_COMMAND;
  wire cmd_autonull = cmd_wr && frame_data == `TCR_CMD_AUTONULL;
  wire cmd_factory = cmd_wr && frame_data == `TCR_CMD_FACTORY;
  wire cmd_flash = cmd_wr && frame_data == `TCR_CMD_FLASH_UPDATE;
  wire status_rd = rd_frame && frame_word == `TCR_OFS_SYSTEM_STATUS >> 1;

  // ==========================================================
  // power-up restore sequencing
  tcr_state_t st_ff;
  tcr_state_t nxt_st;

  always_comb begin
    case (st_ff)
      TCR_ST_LOAD: nxt_st = TCR_ST_RUN;
      TCR_ST_RUN: nxt_st = TCR_ST_RUN;
      default: nxt_st = TCR_ST_LOAD;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      st_ff <= TCR_ST_LOAD;
    end else begin
      st_ff <= nxt_st;
    end
  end

  wire restore = st_ff == TCR_ST_LOAD;

  // ==========================================================
  // nonvolatile image: kept through rst_b, written only by the flash update
  logic [15:0] nv_mem [`TCR_NUM_RW];
  // power-on content of the image store: blank, so the first restore gives reset values
  logic [15:0] nv_sig_ff = 16'h0000;
  logic [15:0] reg_q [`TCR_NUM_RW];

  always_ff @(posedge clk) begin
    if (cmd_flash) begin
      nv_sig_ff <= `TCR_FLASH_SIG;
      for (int i = 0; i < `TCR_NUM_RW; i++) begin
        nv_mem[i] <= reg_q[i];
      end
    end
  end

  // a never-programmed image restores reset values instead
  wire nv_valid = nv_sig_ff == `TCR_FLASH_SIG;

  // ==========================================================
  // offset null arithmetic, all modulo one turn
  logic [13:0] null_val;
  logic [13:0] null_nxt;
  logic [14:0] sum_raw;
  logic [14:0] sum_wrap;
  logic [14:0] an_raw;
  logic [14:0] an_wrap;
  logic [13:0] tilt360_nxt;
  logic [13:0] tilt360_ff;
  logic [13:0] tiltsg_ff;

  assign null_val = reg_q[0][13:0];
  assign sum_raw = {1'b0, tilt_raw} + {1'b0, null_val};
  assign sum_wrap = (sum_raw >= `TCR_TILT_WRAP) ? sum_raw - `TCR_TILT_WRAP : sum_raw;
  assign tilt360_nxt = sum_wrap[13:0];
  // inverse taken against the corrected output so it reads zero afterwards
  assign an_raw = {1'b0, null_val} + `TCR_TILT_WRAP - {1'b0, tilt360_ff};
  assign an_wrap = (an_raw >= `TCR_TILT_WRAP) ? an_raw - `TCR_TILT_WRAP : an_raw;
  assign null_nxt = cmd_factory ? 14'h0000 : an_wrap[13:0];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tilt360_ff <= 14'h0000;
      tiltsg_ff <= 14'h0000;
    end else begin
      tilt360_ff <= tilt360_nxt;
      tiltsg_ff <= (tilt360_nxt >= `TCR_TILT_HALF) ? 14'(tilt360_nxt - `TCR_TILT_WRAP) : tilt360_nxt;
    end
  end

  // ==========================================================
  // control registers
  for (genvar i = 0; i < `TCR_NUM_RW; i++) begin : g_reg
    wire hit = wr_frame && frame_word == RW_OFS[i][5:1];
    wire [15:0] init_val = (NV_MASK[i] && nv_valid) ? nv_mem[i] : `TCR_RW_RESET;
    wire cmd_ld = (i == 0) && (cmd_autonull || cmd_factory);

    tcr_byte_reg #(
      .RESET_VAL(`TCR_RW_RESET)
    ) u_reg (
      .clk(clk),
      .rst_b(rst_b),
      .init(restore),
      .init_val(init_val),
      .wr_lo(hit && !frame_hi),
      .wr_hi(hit && frame_hi),
      .wr_data(frame_data),
      .ld(cmd_ld),
      .ld_val({2'b00, null_nxt}),
      .q(reg_q[i])
    );
    assign ctrl_words[i] = reg_q[i];
  end

  // ==========================================================
  // sticky status; a new event in the clearing read's cycle stays set
  logic frame_err_ff;
  logic null_err_ff;
  wire null_hi_bad = wr_frame && frame_addr == (`TCR_OFS_INCLINE_OFFSET_NULL | 6'h01) && frame_data[7:6] != 2'b00;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      frame_err_ff <= 1'b0;
      null_err_ff <= 1'b0;
    end else begin
      frame_err_ff <= bad_frame | (frame_err_ff & ~status_rd);
      null_err_ff <= null_hi_bad | (null_err_ff & ~status_rd);
    end
  end

  // ==========================================================
  // read selection; command and reserved addresses read zero
  logic [15:0] rd_rw;
  logic [15:0] rd_val;
  logic [15:0] tx_word_ff;

  always_comb begin
    rd_rw = 16'h0000;
    for (int i = 0; i < `TCR_NUM_RW; i++) begin
      if (frame_word == RW_OFS[i][5:1]) begin
        rd_rw = reg_q[i];
      end
    end
  end

  wire [15:0] status_word = {13'h0000, nv_valid, null_err_ff, frame_err_ff};

  assign rd_val = (frame_word == `TCR_OFS_SYSTEM_STATUS >> 1) ? status_word :
                  (frame_word == `TCR_OFS_SYSTEM_COMMAND >> 1) ? 16'h0000 :
                  (frame_word == `TCR_OFS_TILT_360_OUTPUT >> 1) ? {2'b00, tilt360_ff} :
                  (frame_word == `TCR_OFS_TILT_SIGNED_OUTPUT >> 1) ? {2'b00, tiltsg_ff} :
                  rd_rw;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_word_ff <= 16'h0000;
    end else if (rd_frame) begin
      tx_word_ff <= rd_val;
    end
  end

  assign fr.tx_word = tx_word_ff;
  assign tilt_360_output = tilt360_ff;
  assign tilt_signed_output = tiltsg_ff;
endmodule

// [tcr_bank_asserts.sv]
/*
  Concurrent checks on the ports of the tilt control register bank.
  Assumes it is bound to tcr_bank and that the host keeps tilt_raw below 14400.
*/
`timescale 1ns/1ps
module tcr_bank_asserts
  import tcr_pkg::*;
(
  // system
  input wire logic clk,
  input wire logic rst_b,
  // serial pins
  input wire logic spi_sclk,
  input wire logic spi_cs_b,
  input wire logic spi_din,
  input wire logic spi_dout,
  input wire logic spi_dout_oe,
  // angles and contents
  input wire logic [13:0] tilt_raw,
  input wire logic [13:0] tilt_360_output,
  input wire logic [13:0] tilt_signed_output,
  input wire tcr_ctrl_t ctrl_words
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ==========================================================
  // sequences
  sequence s_frame_done;
    !spi_cs_b ##1 spi_cs_b [*8];
  endsequence
  sequence s_driving;
    spi_dout_oe [*8];
  endsequence

  // ==========================================================
  // checks
  a_oe_idle: assert property (spi_cs_b |-> !spi_dout_oe)
    else $error("serial output driven while deselected");
  a_oe_frame: assert property ($fell(spi_cs_b) |-> s_driving)
    else $error("serial output not driven in frame");
  a_offset_sum: assert property ($past(rst_b) |-> tilt_360_output ==
      14'((15'($past(tilt_raw)) + 15'($past(ctrl_words[0][13:0]))) % 15'd14400))
    else $error("corrected angle is not raw plus offset");
  a_signed_fmt: assert property (tilt_signed_output ==
      (tilt_360_output >= 14'd7200 ? 14'(tilt_360_output - 14'd14400) : tilt_360_output))
    else $error("signed angle does not follow corrected angle");
  a_angle_range: assert property (tilt_360_output < 14'd14400)
    else $error("corrected angle out of range");
  // slack of eight cycles covers the crossing and decode of the last frame
  a_ctrl_quiet: assert property (s_frame_done ##1 spi_cs_b |-> $stable(ctrl_words))
    else $error("register changed with no frame");
  a_reset_zero: assert property (disable iff (1'b0) !rst_b |=> ctrl_words == '0)
    else $error("registers not cleared in reset");
  a_volatile_zero: assert property ($rose(rst_b) |=> ctrl_words[6] == 16'h0000 &&
      ctrl_words[7] == 16'h0000 && ctrl_words[11] == 16'h0000)
    else $error("volatile register not zero after restore");
endmodule

// [tcr_host_model.sv]
/*
  Host serial master: mode 3 frames at a 160 ns serial clock.
  Assumes callers start a frame just after a system clock edge.
*/
`timescale 1ns/1ps
module tcr_host_model (
  // serial pins
  output logic sclk,
  output logic cs_b,
  output logic din,
  input wire logic dout,
  input wire logic dout_oe
);
  initial begin
    sclk = 1'b1;
    cs_b = 1'b1;
    din = 1'b0;
  end

  // ==========================================================
  // one frame, msb first; the 13 ns lead keeps edges off the system clock
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    int i;
    #13;
    cs_b = 1'b0;
    #80;
    for (i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      din = w[i];
      #80;
      sclk = 1'b1;
      r[i] = dout;
      #80;
    end
    cs_b = 1'b1;
    din = ~din;
    // long deselect gap lets the core act and load the reply
    #600;
  endtask
endmodule

// [tilt_control_register_bank_tb_top.sv]
/*
  Self-checking bench for the tilt control register bank.
  Assumes tcr_host_model drives the serial pins.
*/
`timescale 1ns/1ps
module tilt_control_register_bank_tb_top;
  import tcr_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [13:0] tilt_raw = 14'h0000;
  wire sclk, cs_b, din, dout, dout_oe;
  logic [13:0] t360, tsgn;
  tcr_ctrl_t ctrl;
  int errors = 0;
  int comparisons = 0;
  logic [5:0] adr [12] = '{6'h18, 6'h20, 6'h22, 6'h24, 6'h26, 6'h28, 6'h30, 6'h32, 6'h34, 6'h36, 6'h38, 6'h3A};

  always #20 clk = ~clk;

  tcr_bank DUT (.clk(clk), .rst_b(rst_b), .spi_sclk(sclk), .spi_cs_b(cs_b), .spi_din(din), .spi_dout(dout),
    .spi_dout_oe(dout_oe), .tilt_raw(tilt_raw), .tilt_360_output(t360), .tilt_signed_output(tsgn),
    .ctrl_words(ctrl));
  tcr_host_model HOST (.sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout), .dout_oe(dout_oe));

  // ==========================================================
  // access and compare tasks
  function automatic logic [15:0] pat(int i, logic [3:0] k);
    return {k, 4'(i), 4'hA, 4'(i)};
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h wanted %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [15:0] r;
    @(posedge clk);
    HOST.xfer({2'b10, a, d}, r);
  endtask
  task automatic check_rd(input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] q;
    @(posedge clk);
    HOST.xfer({2'b00, a, 8'h00}, q);
    @(posedge clk);
    HOST.xfer(16'h0000, q);
    check(q, exp, "register");
  endtask
  task automatic wr_all(input logic [3:0] k);
    int i;
    for (i = 0; i < 12; i++) begin
      wr(adr[i], 8'(pat(i, k)));
      wr(adr[i] | 6'h01, 8'(pat(i, k) >> 8));
    end
  endtask
  task automatic chk_all(input logic [3:0] k, input logic [11:0] keep);
    int i;
    for (i = 0; i < 12; i++) begin
      check_rd(adr[i] | 6'(i % 2), keep[i] ? pat(i, k) : 16'h0000);
      check(ctrl[i], keep[i] ? pat(i, k) : 16'h0000, "ctrl word");
    end
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic angles(input logic [15:0] e360, input logic [15:0] esgn);
    repeat (3) @(posedge clk);
    check({2'b00, t360}, e360, "tilt 360");
    check({2'b00, tsgn}, esgn, "tilt signed");
  endtask
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial begin
    #3ms;
    errors++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial begin
    logic [15:0] q;
    int i;
    do_reset();
    chk_all(4'h0, 12'h000);
    check_rd(6'h00, 16'h0000);
    check_rd(6'h3E, 16'h0000);
    $display("test power_up done");
    wr_all(4'h1);
    chk_all(4'h1, 12'hFFF);
    wr(6'h2A, 8'h55);
    check_rd(6'h2A, 16'h0000);
    wr(6'h3C, 8'hFF);
    check_rd(6'h3C, 16'h0000);
    for (i = 0; i < 2; i++) begin
      @(posedge clk);
      HOST.xfer({(i == 0) ? 2'b11 : 2'b01, 6'h18, 8'hFF}, q);
      check_rd(6'h3C, 16'h0001);
      check(ctrl[0], pat(0, 4'h1), "null kept");
    end
    $display("test byte_access done");
    @(posedge clk) tilt_raw <= 14'd10000;
    angles(16'd14256, 16'h3F70);
    @(posedge clk) tilt_raw <= 14'd14000;
    angles(16'd3856, 16'd3856);
    wr(6'h38, 8'h08);
    wr(6'h3E, 8'h01);
    check_rd(6'h18, 16'h0190);
    angles(16'h0000, 16'h0000);
    wr(6'h38, 8'hAA);
    wr(6'h3E, 8'h02);
    check_rd(6'h18, 16'h0000);
    angles(16'd14000, 16'h3E70);
    wr(6'h18, 8'h2C);
    wr(6'h19, 8'h01);
    angles(16'd14300, 16'h3F9C);
    $display("test offset_null done");
    do_reset();
    chk_all(4'h0, 12'h000);
    wr_all(4'h2);
    wr(6'h3E, 8'h08);
    wr_all(4'h3);
    do_reset();
    chk_all(4'h2, 12'h73F);
    check_rd(6'h3C, 16'h0004);
    $display("test flash_image done");
    wrap_up();
  end
endmodule

bind tcr_bank tcr_bank_asserts u_chk (.clk(clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b),
  .spi_din(spi_din), .spi_dout(spi_dout), .spi_dout_oe(spi_dout_oe), .tilt_raw(tilt_raw),
  .tilt_360_output(tilt_360_output), .tilt_signed_output(tilt_signed_output), .ctrl_words(ctrl_words));
